// file: rtl/ppm_cfg.svh
/*
  ppm_cfg.svh: constants for the pin-mode logic of the expansion bus.
  Assumes inclusion by bare name from rtl/ files.
*/
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
`define PPM_AD_W          32
`define PPM_REQ_W         4
`define PPM_PERR_DLY      2
`define PPM_CLK_MHZ       25
`define PPM_RST_PULSE_NS  1000
`define PPM_RST_PULSE_CYC ((`PPM_RST_PULSE_NS * `PPM_CLK_MHZ) / 1000)
`define PPM_WARM_CYC      16
`endif

// file: rtl/ppm_pkg.sv
/*
  ppm_pkg: types for the pin-mode logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ppm_pkg;
  // phase of the bus as seen by the parity path
  typedef enum logic [3:0] {
    PPM_IDLE  = 4'h1,
    PPM_ADDR  = 4'h2,
    PPM_WDATA = 4'h4,
    PPM_RDATA = 4'h8
  } ppm_phase_t;
endpackage

// file: rtl/ppm_par_if.sv
/*
  ppm_par_if: parity checker request/answer group between top and checker.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface ppm_par_if;
  logic [31:0] data;
  logic        par;
  logic        check;
  logic        gen_par;
  logic        err;
  modport top (output data, output par, output check, input gen_par, input err);
  modport chk (input data, input par, input check, output gen_par, output err);
endinterface

// file: rtl/ppm_par_chk.sv
/*
  ppm_par_chk: even-parity generator and checker with two-clock error report.
  Assumes inputs already synchronised to clk.
*/
`timescale 1ns/1ps
`include "ppm_cfg.svh"
module ppm_par_chk
  import ppm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  ppm_par_if.chk    pi
);
  typedef struct packed {
    logic mis_r;
    logic err_r;
  } ppm_pc_st_t;
  ppm_pc_st_t st_r;
  ppm_pc_st_t st_nxt;

  // even parity over the 32 data lines
  assign pi.gen_par = ^pi.data;

  ////////////////////////////////////////////////////////////////////////
  // mismatch then report: two edges after the data
  always_comb begin
    st_nxt       = st_r;
    st_nxt.mis_r = pi.check && (pi.gen_par != pi.par);
    st_nxt.err_r = st_r.mis_r;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign pi.err = st_r.err_r;

  perr_two_clk_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pi.check && (^pi.data != pi.par)) |-> ##2 pi.err)
    else $error("parity error not reported two clocks after data");
endmodule

// file: rtl/ppm_sync.sv
/*
  ppm_sync: two flip-flop synchroniser for a vector of pin inputs.
  Assumes inputs asynchronous to clk.
*/
`timescale 1ns/1ps
module ppm_sync #(
  parameter int W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  // first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST;
      q    <= RST;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule

// file: rtl/ppm_pins.sv
/*
  ppm_pins: pin direction and role logic of a 32-bit expansion bus port,
  for host mode (internal or external arbiter) and satellite mode.
  Assumes the core supplies phase, request, grant and error events on clk;
  bus pins reach it as in/out/oe triples, resolved outside.
*/
`timescale 1ns/1ps
`include "ppm_cfg.svh"

// Summary of operation
// - parity pin carries even parity over all 32 address/data lines
// - master drives parity in address and write phases, target in reads
// - receiver flags parity mismatch two clocks after the synchronised data arrives
// - host with internal arbiter: all four request lines are inputs
// - host with external arbiter: drive request zero, hold lines one-three high
// - satellite: request zero asks bus, line one is config select, two-three high
// - host drives bus reset whenever a bus reset is wanted
// - satellite: bus reset input starts a warm reset of the device
// - system error on address parity, special-cycle data parity, or other fault
// - target drives stop to end a transaction early, e.g. retry
// - target drives target-ready; data phase completes only with it
// - internal arbiter drives grants; else grant zero is an input
module ppm_pins
  import ppm_pkg::*;
#(
  parameter int AD_W      = `PPM_AD_W,
  parameter int REQ_W     = `PPM_REQ_W,
  parameter int RST_CYC   = `PPM_RST_PULSE_CYC,
  parameter int WARM_CYC  = `PPM_WARM_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             host_mode_strap,
  input  wire logic             int_arb_strap,
  input  wire ppm_phase_t       phase,
  input  wire logic             is_master,
  input  wire logic             is_target,
  input  wire logic             special_cycle,
  input  wire logic             other_sys_err,
  input  wire logic [AD_W-1:0]  ad_out,
  input  wire logic             ad_oe,
  input  wire logic [AD_W-1:0]  addr_data_bus_in,
  input  wire logic             bus_parity_in,
  output logic                  bus_parity_out,
  output logic                  bus_parity_oe,
  input  wire logic             parity_error_n_in,
  output logic                  parity_error_n_out,
  output logic                  parity_error_n_oe,
  input  wire logic             system_error_n_in,
  output logic                  system_error_n_out,
  output logic                  system_error_n_oe,
  input  wire logic             tgt_stop,
  input  wire logic             tgt_ready,
  input  wire logic             irdy,
  input  wire logic             target_stop_n_in,
  output logic                  target_stop_n_out,
  output logic                  target_stop_n_oe,
  input  wire logic             target_ready_n_in,
  output logic                  target_ready_n_out,
  output logic                  target_ready_n_oe,
  input  wire logic             bus_lock_n_in,
  output logic                  lock_seen,
  input  wire logic             own_req,
  input  wire logic [REQ_W-1:0] arb_grant,
  input  wire logic [REQ_W-1:0] bus_request_n_in,
  output logic      [REQ_W-1:0] bus_request_n_out,
  output logic      [REQ_W-1:0] bus_request_n_oe,
  input  wire logic [REQ_W-1:0] bus_grant_n_in,
  output logic      [REQ_W-1:0] bus_grant_n_out,
  output logic      [REQ_W-1:0] bus_grant_n_oe,
  output logic      [REQ_W-1:0] agent_req,
  output logic                  own_gnt,
  output logic                  config_chip_select,
  input  wire logic             bus_reset_req,
  input  wire logic             bus_reset_n_in,
  output logic                  bus_reset_n_out,
  output logic                  bus_reset_n_oe,
  output logic                  warm_reset,
  output logic                  data_done,
  output logic                  parity_err_evt
);
  localparam int CW = 16;

  typedef struct packed {
    logic          cfg_done_r;
    logic          host_r;
    logic          iarb_r;
    logic          par_r;
    logic          par_oe_r;
    logic          rd_lag_r;
    logic          serr_r;
    logic [CW-1:0] rst_cnt_r;
    logic [CW-1:0] warm_cnt_r;
    logic          rst_seen_r;
  } ppm_st_t;

  ppm_st_t st_r;
  ppm_st_t st_nxt;

  logic [AD_W-1:0]  ad_s;
  logic             par_s;
  logic             perr_s;
  logic             lock_s;
  logic             rstin_s;
  logic             trdy_s;
  logic             stop_s;
  logic [REQ_W-1:0] req_s;
  logic [REQ_W-1:0] gnt_s;
  logic             addr_perr;
  logic             data_perr;

  ////////////////////////////////////////////////////////////////////////
  // pin inputs through two flip-flops
  ppm_sync #(.W(AD_W), .RST('0)) u_sync_ad (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (addr_data_bus_in),
    .q     (ad_s)
  );
  ppm_sync #(.W(6 + 2 * REQ_W)) u_sync_ctl (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({bus_parity_in, parity_error_n_in, bus_lock_n_in, bus_reset_n_in,
             target_ready_n_in, target_stop_n_in, bus_request_n_in, bus_grant_n_in}),
    .q     ({par_s, perr_s, lock_s, rstin_s, trdy_s, stop_s, req_s, gnt_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // parity generation and checking
  ppm_par_if pif ();
  assign pif.data  = (phase == PPM_RDATA && !is_master) || phase == PPM_WDATA
                     || phase == PPM_ADDR ? (ad_oe ? ad_out : ad_s) : ad_s;
  assign pif.par   = par_s;
  // check only data this agent receives; address parity is a system error
  assign pif.check = (phase == PPM_WDATA && is_target)
                   || (phase == PPM_RDATA && is_master);
  ppm_par_chk u_par (
    .clk   (clk),
    .rst_n (rst_n),
    .pi    (pif)
  );

  // address parity is checked by every agent that is not the master
  assign addr_perr = phase == PPM_ADDR && !is_master && (pif.gen_par != par_s);
  assign data_perr = pif.check && special_cycle && (pif.gen_par != par_s);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt = st_r;
    // straps caught once, first edge after reset release
    if (!st_r.cfg_done_r) begin
      st_nxt.cfg_done_r = 1'b1;
      st_nxt.host_r     = host_mode_strap;
      st_nxt.iarb_r     = int_arb_strap;
    end
    // parity follows its data by one clock; driver set by role
    st_nxt.par_r    = pif.gen_par;
    st_nxt.par_oe_r = ((phase == PPM_ADDR || phase == PPM_WDATA) && is_master)
                    || (phase == PPM_RDATA && is_target);
    st_nxt.serr_r   = addr_perr || data_perr || other_sys_err;
    // host bus reset pulse, stretched to its least width
    if (st_r.host_r && bus_reset_req) begin
      st_nxt.rst_cnt_r = CW'(RST_CYC);
    end else if (st_r.rst_cnt_r != '0) begin
      st_nxt.rst_cnt_r = st_r.rst_cnt_r - 1'b1;
    end
    // satellite warm reset on falling reset input
    st_nxt.rst_seen_r = !rstin_s;
    if (st_r.cfg_done_r && !st_r.host_r && !rstin_s && !st_r.rst_seen_r) begin
      st_nxt.warm_cnt_r = CW'(WARM_CYC);
    end else if (st_r.warm_cnt_r != '0) begin
      st_nxt.warm_cnt_r = st_r.warm_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parity and error pins (open-drain style for error pins)
  assign bus_parity_out     = st_r.par_r;
  assign bus_parity_oe      = st_r.par_oe_r;
  assign parity_error_n_out = 1'b0;
  assign parity_error_n_oe  = pif.err;
  assign parity_err_evt     = pif.err;
  assign system_error_n_out = 1'b0;
  assign system_error_n_oe  = st_r.serr_r;

  // target termination pins, driven only while target
  assign target_stop_n_out  = !tgt_stop;
  assign target_stop_n_oe   = is_target;
  assign target_ready_n_out = !tgt_ready;
  assign target_ready_n_oe  = is_target;
  // a data phase completes only with irdy high and target ready: its own tgt_ready as target, the synchronised pin low as master
  assign data_done = irdy && (is_target ? tgt_ready : !trdy_s)
                     && (phase == PPM_WDATA || phase == PPM_RDATA);
  assign lock_seen = !lock_s;

  ////////////////////////////////////////////////////////////////////////
  // request, grant and select pins by mode
  always_comb begin
    bus_request_n_out  = '1;
    bus_request_n_oe   = '0;
    bus_grant_n_out    = '1;
    bus_grant_n_oe     = '0;
    agent_req          = '0;
    own_gnt            = 1'b0;
    config_chip_select = 1'b0;
    if (!st_r.cfg_done_r) begin
      bus_request_n_oe = '0;
    end else if (st_r.host_r && st_r.iarb_r) begin
      agent_req       = ~req_s;
      bus_grant_n_out = ~arb_grant;
      bus_grant_n_oe  = '1;
      own_gnt         = 1'b1;
    end else begin
      bus_request_n_oe     = '1;
      bus_request_n_out[0] = !own_req;
      own_gnt              = !gnt_s[0];
      bus_grant_n_oe[REQ_W-1:1] = '1;
      if (!st_r.host_r) begin
        bus_request_n_oe[1] = 1'b0;
        config_chip_select  = !req_s[1];
      end
    end
  end

  // bus reset pin: driven in host and until the straps are caught, input in satellite after that
  assign bus_reset_n_out = !(st_r.rst_cnt_r != '0);
  assign bus_reset_n_oe  = st_r.host_r || !st_r.cfg_done_r;
  assign warm_reset      = st_r.warm_cnt_r != '0;

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence sat_rst_fall;
    !st_r.host_r && st_r.cfg_done_r && !rstin_s && !st_r.rst_seen_r;
  endsequence
  par_drive_role_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == PPM_RDATA && is_target) |=> bus_parity_oe)
    else $error("target not driving parity in read phase");
  // parity launched for driven data matches the data one clock earlier
  par_even_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ad_oe && is_master && (phase == PPM_ADDR || phase == PPM_WDATA))
      |=> (bus_parity_out == ^$past(ad_out)))
    else $error("parity not even over the data lines");
  // request and grant routing by mode
  req_in_iarb_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.host_r && st_r.iarb_r) |-> bus_request_n_oe == '0)
    else $error("request lines driven under internal arbiter");
  req_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.cfg_done_r && st_r.host_r && !st_r.iarb_r)
      |-> (bus_request_n_out[REQ_W-1:1] == '1 && bus_request_n_oe == '1))
    else $error("unused request lines not held high");
  sat_select_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.cfg_done_r && !st_r.host_r) |-> (config_chip_select == !req_s[1]
      && !bus_request_n_oe[1] && bus_request_n_oe[0]))
    else $error("satellite select line misrouted");
  // reset pin roles
  host_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.host_r && bus_reset_req) |=> (!bus_reset_n_out && bus_reset_n_oe))
    else $error("host did not drive bus reset");
  warm_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    sat_rst_fall |=> warm_reset [*2])
    else $error("warm reset not started by reset input");
  // error reporting
  serr_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    (addr_perr || other_sys_err) |=> system_error_n_oe)
    else $error("system error not driven");
  grant_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.host_r && st_r.iarb_r) |-> (bus_grant_n_oe == '1
      && bus_grant_n_out == ~arb_grant))
    else $error("grant lines not driven by internal arbiter");
  strap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.cfg_done_r |=> $stable(st_r.host_r) && $stable(st_r.iarb_r))
    else $error("mode straps changed during operation");
  tgt_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_target && tgt_stop) |-> (target_stop_n_oe && !target_stop_n_out))
    else $error("target stop not driven");
  // a data phase never completes without the target's ready
  done_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((is_target && !tgt_ready) || (!is_target && trdy_s)) |-> !data_done)
    else $error("data phase completed without target ready");
  // special-cycle data parity raises system error
  serr_special_a: assert property (@(posedge clk) disable iff (!rst_n)
    data_perr |=> system_error_n_oe)
    else $error("special-cycle parity error not raised");
  // requests reach the arbiter only in host mode with the internal arbiter
  req_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(st_r.host_r && st_r.iarb_r) |-> (agent_req == '0))
    else $error("requests forwarded without internal arbiter");
  // grant zero is an input and grants one-three sit high otherwise
  grant_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.cfg_done_r && !(st_r.host_r && st_r.iarb_r))
      |-> (!bus_grant_n_oe[0] && bus_grant_n_oe[REQ_W-1:1] == '1
      && bus_grant_n_out[REQ_W-1:1] == '1))
    else $error("grant lines misrouted without internal arbiter");
  // satellite never drives the reset pin once the straps are caught
  sat_rst_in_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.cfg_done_r && !st_r.host_r) |-> !bus_reset_n_oe)
    else $error("satellite drives the reset pin");
endmodule

// file: test/ppm_agent.sv
/*
  ppm_agent: far-side bus agent driving data, parity, lock, request,
  grant zero and reset pins.
  Assumes commands change at the falling edge; pins move after the rising edge.
*/
`timescale 1ns/1ps
module ppm_agent (
  input  wire logic        clk,
  input  wire logic        drv,
  input  wire logic [31:0] dat,
  input  wire logic        bad,
  input  wire logic        lk,
  input  wire logic [3:0]  req_cmd_n,
  input  wire logic        g0_cmd_n,
  input  wire logic        rs_cmd_n,
  output logic      [31:0] ad,
  output logic             par,
  output logic             lock_n,
  output logic      [3:0]  req_n,
  output logic             g0_n,
  output logic             rs_n
);
  ////////////////////////////////////////////////////////////////////////
  // pins follow commands; a released bus toggles each cycle
  always @(posedge clk) begin
    ad     <= drv ? dat : ~ad;
    par    <= drv ? (^dat ^ bad) : ~par;
    lock_n <= ~lk;
    req_n  <= req_cmd_n;
    g0_n   <= g0_cmd_n;
    rs_n   <= rs_cmd_n;
  end
endmodule

// file: test/ppm_pins_test.sv
/*
  ppm_pins_test: self-checking bench for the pin-mode logic.
  Assumes ppm_pkg, the design files and ppm_agent are compiled first.
*/
`timescale 1ns/1ps
module ppm_pins_test
  import ppm_pkg::*;
;
  localparam int RST_CYC  = 4;
  localparam int WARM_CYC = 5;
  logic clk = 1'h0, rst_n, host_mode_strap, int_arb_strap, is_master, is_target;
  logic special_cycle, other_sys_err, ad_oe, bus_parity_in, bus_parity_out, bus_parity_oe;
  logic parity_error_n_in, parity_error_n_out, parity_error_n_oe, system_error_n_in;
  logic system_error_n_out, system_error_n_oe, tgt_stop, tgt_ready, irdy, target_stop_n_in;
  logic target_stop_n_out, target_stop_n_oe, target_ready_n_in, target_ready_n_out;
  logic target_ready_n_oe, bus_lock_n_in, lock_seen, own_req, own_gnt, config_chip_select;
  logic bus_reset_req, bus_reset_n_in, bus_reset_n_out, bus_reset_n_oe, warm_reset;
  logic data_done, parity_err_evt, a_drv, a_bad, a_lk, a_g0_n, a_rs_n, p_par, p_lock_n;
  logic p_g0_n, p_rs_n;
  logic [31:0] ad_out, addr_data_bus_in, a_dat, p_ad;
  logic [3:0]  arb_grant, bus_request_n_in, bus_request_n_out, bus_request_n_oe, a_req_n;
  logic [3:0]  bus_grant_n_in, bus_grant_n_out, bus_grant_n_oe, agent_req, p_req_n;
  ppm_phase_t  phase;
  logic [39:0] notes[$];
  int          cyc = 0, miscompares = 0, tests_run = 0, wl = 0, rl = 0;

  ppm_pins #(.RST_CYC(RST_CYC), .WARM_CYC(WARM_CYC)) ppm_pins_i (.*);
  ppm_agent ppm_agent_i (.clk(clk), .drv(a_drv), .dat(a_dat), .bad(a_bad), .lk(a_lk),
    .req_cmd_n(a_req_n), .g0_cmd_n(a_g0_n), .rs_cmd_n(a_rs_n), .ad(p_ad), .par(p_par),
    .lock_n(p_lock_n), .req_n(p_req_n), .g0_n(p_g0_n), .rs_n(p_rs_n));

  ////////////////////////////////////////////////////////////////////////
  // shared pins resolved from all drivers, pull-ups where released
  assign addr_data_bus_in = ad_oe ? ad_out : p_ad;
  assign bus_parity_in = bus_parity_oe ? bus_parity_out : p_par;
  assign parity_error_n_in = parity_error_n_oe ? parity_error_n_out : 1'h1;
  assign system_error_n_in = system_error_n_oe ? system_error_n_out : 1'h1;
  assign target_stop_n_in = target_stop_n_oe ? target_stop_n_out : 1'h1;
  assign target_ready_n_in = target_ready_n_oe ? target_ready_n_out : 1'h1;
  assign bus_lock_n_in = p_lock_n;
  assign bus_request_n_in = (bus_request_n_oe & bus_request_n_out) | (~bus_request_n_oe & p_req_n);
  assign bus_grant_n_in = (bus_grant_n_oe & bus_grant_n_out) | (~bus_grant_n_oe & {3'h7, p_g0_n});
  assign bus_reset_n_in = bus_reset_n_oe ? bus_reset_n_out : p_rs_n;

  // clock and cycle count
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic note(input logic [7:0] k, input logic [31:0] v);
    notes.push_back({k, v});
  endtask

  // oldest note of this kind; all ones means any cycle
  task automatic take(input logic [7:0] k, input logic [31:0] v);
    int i;
    for (i = 0; i < notes.size(); i++) if (notes[i][39:32] == k) break;
    if (i == notes.size()) chk({24'h0, k}, 32'h0);
    else begin
      if (notes[i][31:0] !== 32'hFFFFFFFF) chk(v, notes[i][31:0]);
      notes.delete(i);
    end
  endtask

  task automatic boot(input logic h, input logic ia);
    @(negedge clk);
    rst_n <= 1'h0;
    host_mode_strap <= h;
    int_arb_strap <= ia;
    repeat (8) @(negedge clk);
    rst_n <= 1'h1;
    repeat (3) @(negedge clk);
  endtask

  task automatic idle;
    @(negedge clk);
    {is_master, is_target, ad_oe, special_cycle} <= 4'h0;
    phase <= PPM_IDLE;
    repeat (16) @(negedge clk);
    chk(notes.size(), 32'h0);
    notes = {};
  endtask

  task conclude;
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // result watcher: events and pulse lengths
  always @(negedge clk) begin
    if (bus_parity_oe === 1'h1) take(8'h01, {31'h0, bus_parity_out});
    if (parity_error_n_oe === 1'h1) begin
      take(8'h02, cyc);
      chk({30'h0, parity_err_evt, parity_error_n_out}, 32'h2);
    end
    if (system_error_n_oe === 1'h1) begin
      take(8'h03, cyc);
      chk({31'h0, system_error_n_out}, 32'h0);
    end
    if (warm_reset === 1'h1) wl++;
    else if (wl != 0) begin
      take(8'h04, wl);
      wl = 0;
    end
    if (bus_reset_n_oe === 1'h1 && bus_reset_n_out === 1'h0) rl++;
    else if (rl != 0) begin
      take(8'h05, rl);
      rl = 0;
    end
  end

  // watchdog
  initial begin
    #200000;
    miscompares++;
    conclude;
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    int k;
    logic [31:0] d;
    logic [3:0] r;
    d = $urandom(32'h36AAB171);
    {rst_n, host_mode_strap, int_arb_strap, is_master, is_target, special_cycle} = 6'h0;
    {other_sys_err, ad_oe, tgt_stop, tgt_ready, irdy, own_req, bus_reset_req} = 7'h0;
    {a_bad, a_lk, ad_out, arb_grant} = 38'h0;
    {a_drv, a_req_n, a_g0_n, a_rs_n} = 7'h7F;
    a_dat = 32'h0;
    phase = PPM_IDLE;
    boot(1'h1, 1'h1);
    // outgoing parity: address, write, read as target, idle
    for (k = 0; k < 16; k++) begin
      d = $urandom;
      @(negedge clk);
      ad_out <= d;
      ad_oe <= (k % 4 != 3);
      phase <= (k % 4 == 0) ? PPM_ADDR : (k % 4 == 1) ? PPM_WDATA :
               (k % 4 == 2) ? PPM_RDATA : PPM_IDLE;
      is_master <= (k % 4 != 2);
      is_target <= (k % 4 == 2);
      if (k % 4 != 3) note(8'h01, {31'h0, ^d});
    end
    idle;
    // one bad parity cycle: write data, special cycle, address
    for (k = 0; k < 3; k++) begin
      @(negedge clk);
      phase <= (k == 2) ? PPM_ADDR : PPM_WDATA;
      is_target <= 1'h1;
      special_cycle <= (k == 1);
      a_dat <= $urandom;
      a_bad <= 1'h1;
      if (k != 2) note(8'h02, cyc + 5);
      if (k != 0) note(8'h03, 32'hFFFFFFFF);
      @(negedge clk);
      a_bad <= 1'h0;
      repeat (6) @(negedge clk);
      idle;
    end
    @(negedge clk);
    other_sys_err <= 1'h1;
    note(8'h03, cyc + 1);
    @(negedge clk);
    other_sys_err <= 1'h0;
    phase <= PPM_WDATA;
    // target stop and ready over all combinations, data completion checked only as target
    for (k = 0; k < 16; k++) begin
      @(negedge clk);
      {is_target, tgt_stop, tgt_ready, irdy} <= k[3:0];
      #1;
      chk(target_stop_n_oe, k[3]);
      chk(target_stop_n_out, k[2] ^ 1'h1);
      chk(target_ready_n_oe, k[3]);
      chk(target_ready_n_out, k[1] ^ 1'h1);
      if (k[3]) chk(data_done, k[1] & k[0]);
    end
    idle;
    // internal arbiter: requests in, grants out, lock, straps frozen
    r = 4'($urandom);
    @(negedge clk);
    a_req_n <= r;
    arb_grant <= r ^ 4'hF;
    a_lk <= 1'h1;
    repeat (4) @(negedge clk);
    chk(bus_request_n_oe, 4'h0);
    chk(agent_req, r ^ 4'hF);
    chk(bus_grant_n_oe, 4'hF);
    chk(bus_grant_n_out, r);
    chk(own_gnt, 1'h1);
    chk(lock_seen, 1'h1);
    a_lk <= 1'h0;
    host_mode_strap <= 1'h0;
    int_arb_strap <= 1'h0;
    repeat (4) @(negedge clk);
    chk(lock_seen, 1'h0);
    chk(bus_request_n_oe, 4'h0);
    chk(bus_grant_n_oe, 4'hF);
    bus_reset_req <= 1'h1;
    note(8'h05, RST_CYC);
    @(negedge clk);
    bus_reset_req <= 1'h0;
    idle;
    // external arbiter
    boot(1'h1, 1'h0);
    for (k = 0; k < 2; k++) begin
      @(negedge clk);
      own_req <= k[0];
      a_g0_n <= k[0] ^ 1'h1;
      repeat (4) @(negedge clk);
      chk(bus_request_n_oe, 4'hF);
      chk(bus_request_n_out, {3'h7, ~k[0]});
      chk(bus_grant_n_oe, 4'hE);
      chk(bus_grant_n_out[3:1], 3'h7);
      chk(own_gnt, k[0]);
    end
    // satellite: select input, reset request refused, warm reset
    boot(1'h0, 1'h0);
    for (k = 0; k < 2; k++) begin
      @(negedge clk);
      own_req <= k[0];
      a_req_n <= {2'h3, k[0], 1'h1};
      bus_reset_req <= 1'h1;
      repeat (4) @(negedge clk);
      chk(bus_request_n_oe, 4'hD);
      chk({bus_request_n_out[3:2], bus_request_n_out[0]}, {2'h3, ~k[0]});
      chk(config_chip_select, k[0] ^ 1'h1);
      chk(bus_reset_n_oe, 1'h0);
      chk(bus_grant_n_oe, 4'hE);
    end
    bus_reset_req <= 1'h0;
    a_rs_n <= 1'h0;
    note(8'h04, WARM_CYC);
    @(negedge clk);
    a_rs_n <= 1'h1;
    idle;
    conclude;
  end
endmodule
